// ### rtl/irq_dma_pkg.sv
// Summary of operation
// R1: Low four select bits pick IRQ line.
// R2: Pin interrupts are active-high edges, except ECP/EPP.
// R3: Chosen line applies to every delivery path.
// R4: Software mirrors parallel IRQ/DMA into shadow register.
// R5: Both serial ports may share one IRQ pin.
// R6: IRQ needs nonzero select plus device enable.
// R7: Parallel IRQ needs enable bit; ECP needs service clear.
// R8: Serial IRQ needs an enable bit and aux out.
// R9: Unselected IRQ pins float.
// R10: DMA select 0-3 picks channel, 4-7 none.
// R11: DMA needs channel select plus device enable.
// R12: Unselected DMA request pins float.
// R13: Disabled device releases IRQ and DMA acknowledge.
// R14: Floppy gate off or powerdown floats IRQ/acknowledge.
// R15: First serial aux out low floats its IRQ.
// R16: Second serial aux out low floats its IRQ.
// R17: Sync-serial DMA enable low floats request pin.
// R18: SPP/EPP parallel IRQ floats without enable bit.
// R19: Modes 010/011/110 force parallel IRQ on.
// R20: Gating follows registers, effective next clock.
package irq_dma_pkg;

   localparam int N_DEV = 4;
   localparam int N_IRQ = 16;
   localparam int N_DMA = 4;

   localparam int DEV_FDC = 0;
   localparam int DEV_PP  = 1;
   localparam int DEV_SP1 = 2;
   localparam int DEV_SP2 = 3;

   localparam logic [7:0] OFF_DEV_SEL  = 8'h00;
   localparam logic [7:0] OFF_ACTIVATE = 8'h30;
   localparam logic [7:0] OFF_IRQ_SEL  = 8'h70;
   localparam logic [7:0] OFF_DMA_SEL  = 8'h74;
   localparam logic [7:0] OFF_GATE     = 8'h80;
   localparam logic [7:0] OFF_STATUS   = 8'h84;

   // Activate register fields.
   localparam int POS_ACTIVE     = 0;
   localparam int POS_ADDR_VALID = 1;

   // Gate control register fields.
   localparam int POS_FDC_GATE   = 0;
   localparam int POS_FDC_PD     = 1;
   localparam int POS_PP_PP_IRQ_ENABLE    = 2;
   localparam int POS_ECR_MODE   = 3;
   localparam int POS_ECP_SVC    = 6;
   localparam int POS_ECP_FDC_DMA_GATE  = 7;
   localparam int POS_SP1_IER    = 8;
   localparam int POS_SP1_AUX    = 12;
   localparam int POS_SP2_IER    = 13;
   localparam int POS_SP2_AUX    = 17;
   localparam int POS_SYNC_FDC_DMA_GATE = 18;

   // Status register fields.
   localparam int POS_ST_IRQ_OE  = 0;
   localparam int POS_ST_DRQ_OE  = 16;

   localparam logic [3:0] IRQ_NONE      = 4'h0;
   localparam logic [2:0] DMA_SEL_RESET = 3'h4;
   localparam logic [3:0] IRQ_SEL_RESET = 4'h0;

   localparam logic [2:0] MODE_SPP0 = 3'b000;
   localparam logic [2:0] MODE_SPP1 = 3'b001;
   localparam logic [2:0] MODE_FIFO = 3'b010;
   localparam logic [2:0] MODE_ECP  = 3'b011;
   localparam logic [2:0] MODE_EPP  = 3'b100;
   localparam logic [2:0] MODE_TEST = 3'b110;

endpackage

// ### rtl/irq_router.sv
`timescale 1ns/1ps
// Drives each IRQ pin from the OR of all enabled devices that select it.
module irq_router #(
   parameter int N_DEV = 4,
   parameter int N_PIN = 16
) (
   // Device side
   input  wire logic [N_DEV-1:0][3:0] sel,
   input  wire logic [N_DEV-1:0]      en,
   input  wire logic [N_DEV-1:0]      level,
   // Pin side
   output logic      [N_PIN-1:0]      pin_out,
   output logic      [N_PIN-1:0]      pin_oe
);

   genvar p;
   generate
      for (p = 0; p < N_PIN; p++) begin : g_pin
         logic [N_DEV-1:0] hit;
         always_comb begin
            for (int d = 0; d < N_DEV; d++) begin
               // Several devices may land on one pin and share it. [R5]
               hit[d] = en[d] && (sel[d] == 4'(p));
            end
         end
         // A pin nobody selects stays released. [R9]
         assign pin_oe[p]  = |hit;
         assign pin_out[p] = |(hit & level);
      end
   endgenerate

endmodule

// ### rtl/dma_router.sv
`timescale 1ns/1ps
// Routes device requests to channel pins and channel acks back.
module dma_router #(
   parameter int N_DEV = 4,
   parameter int N_CH  = 4
) (
   // Device side
   input  wire logic [N_DEV-1:0][2:0] sel,
   input  wire logic [N_DEV-1:0]      en,
   input  wire logic [N_DEV-1:0]      req,
   output logic      [N_DEV-1:0]      dev_ack_n,
   // Channel side
   input  wire logic [N_CH-1:0]       ch_ack_n,
   output logic      [N_CH-1:0]       pin_out,
   output logic      [N_CH-1:0]       pin_oe
);

   genvar c;
   generate
      for (c = 0; c < N_CH; c++) begin : g_ch
         logic [N_DEV-1:0] hit;
         always_comb begin
            for (int d = 0; d < N_DEV; d++) begin
               hit[d] = en[d] && (sel[d] == 3'(c));
            end
         end
         // Unused request pins float. [R12]
         assign pin_oe[c]  = |hit;
         assign pin_out[c] = |(hit & req);
      end
   endgenerate

   always_comb begin
      for (int d = 0; d < N_DEV; d++) begin
         // A disabled device never sees an acknowledge. [R13]
         dev_ack_n[d] = en[d] ? ch_ack_n[sel[d][1:0]] : 1'b1;
      end
   end

endmodule

// ### rtl/irq_dma_routing_gating.sv
`timescale 1ns/1ps
module irq_dma_routing_gating (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Device interrupt and DMA requests, same clock
   input  wire logic        fdc_irq_event,
   input  wire logic        pp_irq_event,
   input  wire logic        sp1_irq_event,
   input  wire logic        sp2_irq_event,
   input  wire logic        fdc_dma_req,
   input  wire logic        pp_dma_request,
   input  wire logic        sp2_dma_req,
   // Per-device acknowledges, active low
   output logic      [3:0]  dev_dma_ack_n,
   // Host-side pins
   output logic      [15:0] irq_pin_out,
   output logic      [15:0] irq_pin_oe,
   output logic      [3:0]  dma_request_pins_out,
   output logic      [3:0]  dma_request_pins_oe,
   input  wire logic [3:0]  dma_ack_n
);

   localparam int ND = irq_dma_pkg::N_DEV;

   typedef struct packed {
      logic [1:0]           dev_sel;
      logic [ND-1:0]        activate;
      logic [ND-1:0]        addr_valid;
      logic [ND-1:0][3:0]   irq_sel;
      logic [ND-1:0][2:0]   dma_sel;
      logic                 fdc_dma_gate;
      logic                 fdc_powerdown;
      logic                 pp_irq_enable;
      logic [2:0]           ecr_mode;
      logic                 ecp_service_int;
      logic                 ecp_dma_enable;
      logic [3:0]           sp1_int_enable;
      logic                 sp1_modem_aux_out;
      logic [3:0]           sp2_int_enable;
      logic                 sp2_modem_aux_out;
      logic                 sync_dma_enable;
      logic [31:0]          rdata;
      logic                 slverr;
      logic [15:0]          irq_out;
      logic [15:0]          irq_oe;
      logic [3:0]           drq_out;
      logic [3:0]           drq_oe;
      logic [ND-1:0]        dack_n;
      logic [3:0]           ack_meta;
      logic [3:0]           ack_sync;
   } state_s;

   state_s s;
   state_s next_s;

   logic [ND-1:0] dev_irq_gate;
   logic [ND-1:0] dev_dma_gate;
   logic [ND-1:0] cfg_ok;
   logic [ND-1:0] irq_en;
   logic [ND-1:0] dma_en;
   logic [ND-1:0] irq_level;
   logic [ND-1:0] dma_req;
   logic [ND-1:0] ack_to_dev;
   logic [15:0]   irq_pin_next;
   logic [15:0]   irq_oe_next;
   logic [3:0]    drq_pin_next;
   logic [3:0]    drq_oe_next;
   logic          pp_irq_forced;
   logic          pp_active_low;
   logic [31:0]   gate_word;
   logic          setup;
   logic          wr_access;
   logic          addr_hit;
   logic [7:0]    word_addr;

   // Device-specific enable conditions.
   always_comb begin
      pp_irq_forced = (s.ecr_mode == irq_dma_pkg::MODE_FIFO) ||
                      (s.ecr_mode == irq_dma_pkg::MODE_ECP)  ||
                      (s.ecr_mode == irq_dma_pkg::MODE_TEST); // [R19]
      // Floppy needs its gate and must not be powered down. [R6] [R14]
      dev_irq_gate[irq_dma_pkg::DEV_FDC] = s.fdc_dma_gate &&
                                           !s.fdc_powerdown;
      // Parallel port follows its enable unless the mode forces it on,
      // and ECP mode also needs the service bit cleared. [R7] [R18]
      dev_irq_gate[irq_dma_pkg::DEV_PP] =
         (pp_irq_forced || s.pp_irq_enable) &&
         !((s.ecr_mode == irq_dma_pkg::MODE_ECP) && s.ecp_service_int);
      // Serial ports need an enabled source and the aux output. [R8]
      dev_irq_gate[irq_dma_pkg::DEV_SP1] = (|s.sp1_int_enable) &&
                                           s.sp1_modem_aux_out; // [R15]
      dev_irq_gate[irq_dma_pkg::DEV_SP2] = (|s.sp2_int_enable) &&
                                           s.sp2_modem_aux_out; // [R16]

      dev_dma_gate[irq_dma_pkg::DEV_FDC] = s.fdc_dma_gate &&
                                           !s.fdc_powerdown; // [R11]
      dev_dma_gate[irq_dma_pkg::DEV_PP]  = s.ecp_dma_enable; // [R4]
      dev_dma_gate[irq_dma_pkg::DEV_SP1] = 1'b0;
      dev_dma_gate[irq_dma_pkg::DEV_SP2] = s.sync_dma_enable; // [R17]

      // Pin interrupts are active-high levels whose rising edge is the
      // request; only ECP and EPP modes drive the parallel line low. [R2]
      pp_active_low = (s.ecr_mode == irq_dma_pkg::MODE_ECP) ||
                      (s.ecr_mode == irq_dma_pkg::MODE_EPP);
      irq_level[irq_dma_pkg::DEV_FDC] = fdc_irq_event;
      irq_level[irq_dma_pkg::DEV_PP]  = pp_irq_event ^ pp_active_low;
      irq_level[irq_dma_pkg::DEV_SP1] = sp1_irq_event;
      irq_level[irq_dma_pkg::DEV_SP2] = sp2_irq_event;

      dma_req[irq_dma_pkg::DEV_FDC] = fdc_dma_req;
      dma_req[irq_dma_pkg::DEV_PP]  = pp_dma_request;
      dma_req[irq_dma_pkg::DEV_SP1] = 1'b0;
      dma_req[irq_dma_pkg::DEV_SP2] = sp2_dma_req;

      for (int d = 0; d < ND; d++) begin
         cfg_ok[d] = s.activate[d] && s.addr_valid[d]; // [R13]
         irq_en[d] = cfg_ok[d] && dev_irq_gate[d] &&
                     (s.irq_sel[d] != irq_dma_pkg::IRQ_NONE); // [R1] [R6]
         dma_en[d] = cfg_ok[d] && dev_dma_gate[d] &&
                     !s.dma_sel[d][2]; // [R10] [R11]
      end
   end

   // One selection feeds the pin path, whichever delivery is in use. [R3]
   irq_router #(
      .N_DEV (ND),
      .N_PIN (irq_dma_pkg::N_IRQ)
   ) u_irq_router (
      .sel     (s.irq_sel),
      .en      (irq_en),
      .level   (irq_level),
      .pin_out (irq_pin_next),
      .pin_oe  (irq_oe_next)
   );

   dma_router #(
      .N_DEV (ND),
      .N_CH  (irq_dma_pkg::N_DMA)
   ) u_dma_router (
      .sel       (s.dma_sel),
      .en        (dma_en),
      .req       (dma_req),
      .dev_ack_n (ack_to_dev),
      .ch_ack_n  (s.ack_sync),
      .pin_out   (drq_pin_next),
      .pin_oe    (drq_oe_next)
   );

   always_comb begin
      gate_word = 32'h0000_0000;
      gate_word[irq_dma_pkg::POS_FDC_GATE]   = s.fdc_dma_gate;
      gate_word[irq_dma_pkg::POS_FDC_PD]     = s.fdc_powerdown;
      gate_word[irq_dma_pkg::POS_PP_PP_IRQ_ENABLE]    = s.pp_irq_enable;
      gate_word[irq_dma_pkg::POS_ECR_MODE +: 3] = s.ecr_mode;
      gate_word[irq_dma_pkg::POS_ECP_SVC]    = s.ecp_service_int;
      gate_word[irq_dma_pkg::POS_ECP_FDC_DMA_GATE]  = s.ecp_dma_enable;
      gate_word[irq_dma_pkg::POS_SP1_IER +: 4] = s.sp1_int_enable;
      gate_word[irq_dma_pkg::POS_SP1_AUX]    = s.sp1_modem_aux_out;
      gate_word[irq_dma_pkg::POS_SP2_IER +: 4] = s.sp2_int_enable;
      gate_word[irq_dma_pkg::POS_SP2_AUX]    = s.sp2_modem_aux_out;
      gate_word[irq_dma_pkg::POS_SYNC_FDC_DMA_GATE] = s.sync_dma_enable;
   end

   assign setup     = psel && !penable;
   assign wr_access = psel && penable && pwrite;
   assign word_addr = {paddr[7:2], 2'b00};
   assign addr_hit  = (paddr[1:0] == 2'b00) &&
                      ((word_addr == irq_dma_pkg::OFF_DEV_SEL)  ||
                       (word_addr == irq_dma_pkg::OFF_ACTIVATE) ||
                       (word_addr == irq_dma_pkg::OFF_IRQ_SEL)  ||
                       (word_addr == irq_dma_pkg::OFF_DMA_SEL)  ||
                       (word_addr == irq_dma_pkg::OFF_GATE)     ||
                       (word_addr == irq_dma_pkg::OFF_STATUS));

   always_comb begin
      next_s = s;
      // Two-flop synchroniser on the host acknowledge pins.
      next_s.ack_meta = dma_ack_n;
      next_s.ack_sync = s.ack_meta;
      // Outputs follow the registers one clock later, no host action. [R20]
      next_s.irq_out = irq_pin_next;
      next_s.irq_oe  = irq_oe_next; // [R9]
      next_s.drq_out = drq_pin_next;
      next_s.drq_oe  = drq_oe_next; // [R12]
      next_s.dack_n  = ack_to_dev; // [R13] [R14]

      // Read data and error are latched in the setup cycle so that the
      // zero-wait access phase presents them from flops.
      if (setup) begin
         next_s.slverr = !addr_hit;
         next_s.rdata  = 32'h0000_0000;
         case (paddr)
            irq_dma_pkg::OFF_DEV_SEL:
               next_s.rdata[1:0] = s.dev_sel;
            irq_dma_pkg::OFF_ACTIVATE: begin
               next_s.rdata[irq_dma_pkg::POS_ACTIVE] = s.activate[s.dev_sel];
               next_s.rdata[irq_dma_pkg::POS_ADDR_VALID] =
                  s.addr_valid[s.dev_sel];
            end
            irq_dma_pkg::OFF_IRQ_SEL:
               next_s.rdata[3:0] = s.irq_sel[s.dev_sel];
            irq_dma_pkg::OFF_DMA_SEL:
               next_s.rdata[2:0] = s.dma_sel[s.dev_sel];
            irq_dma_pkg::OFF_GATE:
               next_s.rdata = gate_word;
            irq_dma_pkg::OFF_STATUS: begin
               next_s.rdata[irq_dma_pkg::POS_ST_IRQ_OE +: 16] = s.irq_oe;
               next_s.rdata[irq_dma_pkg::POS_ST_DRQ_OE +: 4]  = s.drq_oe;
            end
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end

      if (wr_access && addr_hit) begin
         case (word_addr)
            irq_dma_pkg::OFF_DEV_SEL:
               next_s.dev_sel = pwdata[1:0];
            irq_dma_pkg::OFF_ACTIVATE: begin
               next_s.activate[s.dev_sel] =
                  pwdata[irq_dma_pkg::POS_ACTIVE];
               next_s.addr_valid[s.dev_sel] =
                  pwdata[irq_dma_pkg::POS_ADDR_VALID];
            end
            irq_dma_pkg::OFF_IRQ_SEL:
               next_s.irq_sel[s.dev_sel] = pwdata[3:0]; // [R1]
            irq_dma_pkg::OFF_DMA_SEL:
               next_s.dma_sel[s.dev_sel] = pwdata[2:0]; // [R10]
            irq_dma_pkg::OFF_GATE: begin
               next_s.fdc_dma_gate  = pwdata[irq_dma_pkg::POS_FDC_GATE];
               next_s.fdc_powerdown = pwdata[irq_dma_pkg::POS_FDC_PD];
               next_s.pp_irq_enable = pwdata[irq_dma_pkg::POS_PP_PP_IRQ_ENABLE];
               next_s.ecr_mode = pwdata[irq_dma_pkg::POS_ECR_MODE +: 3];
               next_s.ecp_service_int = pwdata[irq_dma_pkg::POS_ECP_SVC];
               next_s.ecp_dma_enable  = pwdata[irq_dma_pkg::POS_ECP_FDC_DMA_GATE];
               next_s.sp1_int_enable =
                  pwdata[irq_dma_pkg::POS_SP1_IER +: 4];
               next_s.sp1_modem_aux_out = pwdata[irq_dma_pkg::POS_SP1_AUX];
               next_s.sp2_int_enable =
                  pwdata[irq_dma_pkg::POS_SP2_IER +: 4];
               next_s.sp2_modem_aux_out = pwdata[irq_dma_pkg::POS_SP2_AUX];
               next_s.sync_dma_enable =
                  pwdata[irq_dma_pkg::POS_SYNC_FDC_DMA_GATE];
            end
            default: next_s.dev_sel = s.dev_sel;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         for (int d = 0; d < ND; d++) begin
            s.irq_sel[d] <= irq_dma_pkg::IRQ_SEL_RESET;
            s.dma_sel[d] <= irq_dma_pkg::DMA_SEL_RESET;
         end
         s.dack_n   <= '1;
         s.ack_meta <= '1;
         s.ack_sync <= '1;
      end else begin
         s <= next_s;
      end
   end

   assign pready               = 1'b1;
   assign prdata               = s.rdata;
   assign pslverr              = s.slverr;
   assign irq_pin_out          = s.irq_out;
   assign irq_pin_oe           = s.irq_oe;
   assign dma_request_pins_out = s.drq_out;
   assign dma_request_pins_oe  = s.drq_oe;
   assign dev_dma_ack_n        = s.dack_n;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_fdc_gate_off: assert property ( // [R14]
      (!s.fdc_dma_gate || s.fdc_powerdown) |=>
         $past(!irq_en[irq_dma_pkg::DEV_FDC]) &&
         s.dack_n[irq_dma_pkg::DEV_FDC])
      else $error("floppy released late after gate off");

   a_sp1_aux_low: assert property ( // [R15]
      !s.sp1_modem_aux_out |-> !irq_en[irq_dma_pkg::DEV_SP1])
      else $error("first serial irq enabled with aux low");

   a_sp2_aux_low: assert property ( // [R16]
      !s.sp2_modem_aux_out |-> !irq_en[irq_dma_pkg::DEV_SP2])
      else $error("second serial irq enabled with aux low");

   a_sync_drq_float: assert property ( // [R17]
      !s.sync_dma_enable |-> !dma_en[irq_dma_pkg::DEV_SP2])
      else $error("sync serial request driven while disabled");

   a_irq_sel_zero: assert property ( // [R1]
      (s.irq_sel[irq_dma_pkg::DEV_PP] == irq_dma_pkg::IRQ_NONE) |->
         !irq_en[irq_dma_pkg::DEV_PP])
      else $error("parallel irq enabled with no line selected");

   a_dma_none_sel: assert property ( // [R10]
      s.dma_sel[irq_dma_pkg::DEV_FDC][2] |=>
         s.dack_n[irq_dma_pkg::DEV_FDC])
      else $error("floppy acknowledged with no channel");

   a_pp_spp_gate: assert property ( // [R18]
      ((s.ecr_mode == irq_dma_pkg::MODE_SPP0 ||
        s.ecr_mode == irq_dma_pkg::MODE_EPP) && !s.pp_irq_enable) |->
         !irq_en[irq_dma_pkg::DEV_PP])
      else $error("parallel irq enabled without enable bit");

   a_irq_route_pin: assert property ( // [R3]
      (irq_en[irq_dma_pkg::DEV_FDC] &&
       s.irq_sel[irq_dma_pkg::DEV_FDC] == 4'h6 && fdc_irq_event) |=>
         s.irq_oe[6] && s.irq_out[6])
      else $error("floppy irq not on selected pin");

   a_irq_pin0_float: assert property ( // [R9]
      !s.irq_oe[0] && !s.irq_out[0])
      else $error("unselectable irq pin driven");

   a_irq_sel_write: assert property ( // [R20]
      (psel && penable && pwrite &&
       paddr == irq_dma_pkg::OFF_IRQ_SEL) |=>
         s.irq_sel[$past(s.dev_sel)] == $past(pwdata[3:0]))
      else $error("interrupt select write lost");

   c_serial_share: cover property (
      irq_en[irq_dma_pkg::DEV_SP1] && irq_en[irq_dma_pkg::DEV_SP2] &&
      s.irq_sel[irq_dma_pkg::DEV_SP1] == s.irq_sel[irq_dma_pkg::DEV_SP2]);
   c_pp_forced: cover property (
      pp_irq_forced && !s.pp_irq_enable && irq_en[irq_dma_pkg::DEV_PP]);
   c_fdc_dma: cover property (
      dma_en[irq_dma_pkg::DEV_FDC] && fdc_dma_req ##1 |s.drq_out);

endmodule

// ### verification/isa_host_model.sv
`timescale 1ns/1ps
// Host DMA controller: grants a driven-high request, promptly or slowly.
module isa_host_model (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Request pins and pacing
   input  wire logic [3:0] req_out,
   input  wire logic [3:0] req_oe,
   input  wire logic       slow,
   // Grant, active low
   output logic      [3:0] ack_n
);
   logic [3:0][2:0] cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt   <= '0;
         ack_n <= 4'hf;
      end else begin
         for (int i = 0; i < 4; i++) begin
            // A floating pin is never taken as a request.
            if (!(req_oe[i] && req_out[i])) begin
               cnt[i]   <= 3'h0;
               ack_n[i] <= 1'b1;
            end else if (cnt[i] >= (slow ? 3'h5 : 3'h0)) begin
               ack_n[i] <= 1'b0;
            end else begin
               cnt[i] <= cnt[i] + 3'h1;
            end
         end
      end
   end
endmodule

// ### verification/irq_dma_routing_gating_tb_top.sv
`timescale 1ns/1ps
module irq_dma_routing_gating_tb_top;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  ev      = 4'h0;
   logic [2:0]  dreq    = 3'h0;
   logic        slow    = 1'b0;
   logic [3:0]  ack_n;
   logic [3:0]  host_ack_n;
   logic [15:0] irq_out;
   logic [15:0] irq_oe;
   logic [3:0]  drq_out;
   logic [3:0]  drq_oe;
   logic [3:0]  s;
   logic [32:0] rd_q [$];
   logic [31:0] sg [4] = '{32'h23100, 32'h22100, 32'h03100, 32'h23000};
   logic [31:0] se [4] = '{32'h30, 32'h20, 32'h10, 32'h20};
   int          n_fail  = 0;
   int          n_tests = 0;
   int          seed    = 33;

   always #50 pclk = ~pclk;

   irq_dma_routing_gating DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .fdc_irq_event(ev[0]), .pp_irq_event(ev[1]),
      .sp1_irq_event(ev[2]), .sp2_irq_event(ev[3]),
      .fdc_dma_req(dreq[0]), .pp_dma_request(dreq[1]),
      .sp2_dma_req(dreq[2]), .dev_dma_ack_n(ack_n),
      .irq_pin_out(irq_out), .irq_pin_oe(irq_oe),
      .dma_request_pins_out(drq_out), .dma_request_pins_oe(drq_oe),
      .dma_ack_n(host_ack_n)
   );

   isa_host_model host (
      .pclk(pclk), .presetn(presetn), .req_out(drq_out),
      .req_oe(drq_oe), .slow(slow), .ack_n(host_ack_n)
   );

   task automatic check(input string name, input logic [32:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // The request is held until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   // Pin gating is registered, so let it settle before reading status.
   task automatic st(input logic [31:0] e);
      repeat (4) @(posedge pclk);
      check("pin oe", {13'h0, drq_oe, irq_oe}, {13'h0, e[19:0]});
      rd(8'h84, {1'b0, e});
   endtask

   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         check("apb read", {pslverr, prdata}, rd_q.pop_front());
      end
   end

   initial begin
      repeat (5000) @(posedge pclk);
      n_fail++;
      tally_and_finish();
   end

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h70, 33'h0);
      rd(8'h74, 33'h4);
      st(32'h0);
      rd(8'h44, 33'h1_0000_0000);
      rd(8'h75, 33'h1_0000_0000);
      wr(8'h30, 32'h3);
      wr(8'h70, 32'h6);
      wr(8'h74, 32'h2);
      wr(8'h80, 32'h1);
      ev[0]   <= 1'b1;
      dreq[0] <= 1'b1;
      st(32'h0004_0040);
      check("fdc irq level", {32'h0, irq_out[6]}, 33'h1);
      check("fdc ack", {29'h0, ack_n}, 33'he);
      wr(8'h80, 32'h3);
      st(32'h0);
      check("fdc ack off", {29'h0, ack_n}, 33'hf);
      wr(8'h80, 32'h1);
      wr(8'h30, 32'h1);
      st(32'h0);
      wr(8'h30, 32'h3);
      wr(8'h74, 32'h4);
      st(32'h40);
      for (int i = 0; i < 6; i++) begin
         s = 4'($random(seed));
         wr(8'h70, {28'h0, s});
         st(s == 4'h0 ? 32'h0 : 32'h1 << s);
      end
      wr(8'h70, 32'h0);
      st(32'h0);
      ev <= 4'hf;
      wr(8'h00, 32'h2);
      wr(8'h30, 32'h3);
      wr(8'h70, 32'h4);
      wr(8'h00, 32'h3);
      wr(8'h30, 32'h3);
      wr(8'h70, 32'h5);
      for (int i = 0; i < 4; i++) begin
         wr(8'h80, sg[i]);
         st(se[i]);
      end
      wr(8'h70, 32'h4);
      wr(8'h80, 32'h23100);
      st(32'h10);
      wr(8'h00, 32'h1);
      wr(8'h30, 32'h3);
      wr(8'h70, 32'h7);
      for (int m = 0; m < 8; m++) begin
         wr(8'h80, 32'(m) << 3);
         st((m == 2 || m == 3 || m == 6) ? 32'h80 : 32'h0);
      end
      wr(8'h80, 32'h58);
      st(32'h0);
      wr(8'h80, 32'h4);
      st(32'h80);
      wr(8'h74, 32'h1);
      slow    <= 1'b1;
      dreq[1] <= 1'b1;
      // Software mirrors the parallel DMA choice into the gate word.
      wr(8'h80, 32'h80);
      st(32'h2_0000);
      repeat (12) @(posedge pclk);
      check("pp ack", {29'h0, ack_n}, 33'hd);
      wr(8'h00, 32'h3);
      wr(8'h74, 32'h3);
      wr(8'h80, 32'h4_0080);
      st(32'ha_0000);
      check("sync drq idle", {32'h0, drq_out[3]}, 33'h0);
      dreq[2] <= 1'b1;
      repeat (3) @(posedge pclk);
      check("sync drq busy", {32'h0, drq_out[3]}, 33'h1);
      wr(8'h80, 32'h80);
      st(32'h2_0000);
      tally_and_finish();
   end
endmodule
